// [design/instr_exec_defs.svh]
`ifndef INSTR_EXEC_DEFS_SVH
`define INSTR_EXEC_DEFS_SVH

// register byte offsets
`define REG_WORKING_OFS      12'h000
`define REG_PC_HIGH_OFS      12'h004
`define REG_PC_OFS           12'h008
`define REG_STATUS_OFS       12'h00C

// status register bit positions
`define STATUS_ZERO_BIT      0
`define STATUS_POWERDOWN_BIT 1
`define STATUS_TIMEOUT_BIT   2

// reset values
`define WORKING_RST          8'h00
`define PC_HIGH_RST          8'h00
`define PC_RST               15'h0000
`define ZERO_RST             1'b0
`define FLAG_N_RST           1'b1

// cleared values and steps
`define CLEAR_BYTE           8'h00
`define WATCHDOG_CLEAR_VAL   8'h00
`define ONE_BYTE             8'h01
`define ONE_PC               15'h0001

// axi responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// [design/instr_exec_pkg.sv]
package instr_exec_pkg;

   typedef enum logic [2:0] {
      no_operation,
      watchdog_clear_instr,
      call_via_working_reg_instr,
      complement_reg_instr,
      clear_reg_instr,
      clear_working_reg_instr,
      decrement_reg_instr,
      decrement_skip_zero_instr
   } op_type;

   typedef enum logic {
      st_exec,
      st_second
   } phase_type;

   typedef struct packed {
      phase_type   phase;
      logic [7:0]  working;
      logic [7:0]  pc_high_latch;
      logic [14:0] pc;
      logic        zero;
      logic        timeout_flag_n;
      logic        powerdown_flag_n;
      logic        push;
      logic [14:0] push_addr;
      logic        wdt_clear;
      logic        skip;
      logic        file_we;
      logic [6:0]  file_waddr;
      logic [7:0]  file_wdata;
      logic        aw_held;
      logic [11:0] awaddr;
      logic        w_held;
      logic [7:0]  wdata;
      logic        wstrb0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } state_type;

endpackage : instr_exec_pkg

// [design/instruction_exec_subset.sv]
// Behaviour
// - watchdog clear zeroes the watchdog counter and its prescaler
// - watchdog clear sets timeout and powerdown flags to one, nothing else
// - call via working register pushes current pc plus one onto stack
// - call via working register loads working register into pc bits 7..0
// - call loads pc high latch bits 6..0 into pc 14..8, flags unchanged
// - call via working register takes two instruction cycles
// - destination bit zero writes working register, one writes file register
// - complement inverts file register, stores to destination, updates zero
// - clear register writes 00h to file register and sets zero flag
// - clear working register writes 00h to working register, sets zero
// - decrement subtracts one, stores to destination, updates zero flag
// - decrement skip leaves flags, discards next instruction when zero
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`include "instr_exec_defs.svh"

module instruction_exec_subset (
   // clock and reset
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_i,
   // instruction issue
   input  wire logic                  instr_valid_i,
   output logic                       instr_ready_o,
   input  wire instr_exec_pkg::op_type instr_op_i,
   input  wire logic [6:0]            instr_faddr_i,
   input  wire logic                  instr_dest_i,
   // file register port
   output logic [6:0]                 file_raddr_o,
   input  wire logic [7:0]            file_rdata_i,
   output logic                       file_we_o,
   output logic [6:0]                 file_waddr_o,
   output logic [7:0]                 file_wdata_o,
   // return stack, watchdog and fetch control
   output logic                       stack_push_o,
   output logic [14:0]                stack_push_addr_o,
   output logic                       wdt_clear_o,
   output logic                       prescaler_clear_o,
   output logic                       skip_next_o,
   output logic [14:0]                pc_o,
   // axi4-lite write address
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [11:0]           s_axi_awaddr,
   // axi4-lite write data
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   // axi4-lite write response
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output logic [1:0]                 s_axi_bresp,
   // axi4-lite read
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   input  wire logic [11:0]           s_axi_araddr,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp
);
   import instr_exec_pkg::*;

   state_type cur_ff;
   state_type nxt_cur;
   logic      issue;
   logic      wr_fire;
   logic      rd_fire;
   logic [7:0] dec_val;
   logic [7:0] com_val;

   // one place decides which offsets are mapped, for both read and write responses
   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a == `REG_WORKING_OFS) || (a == `REG_PC_HIGH_OFS) ||
                    (a == `REG_PC_OFS) || (a == `REG_STATUS_OFS);
   endfunction : addr_mapped

   function automatic logic [31:0] read_word(input logic [11:0] a,
                                             input state_type s);
      read_word = 32'h0000_0000;
      if (a == `REG_WORKING_OFS) begin
         read_word[7:0] = s.working;
      end else if (a == `REG_PC_HIGH_OFS) begin
         read_word[7:0] = s.pc_high_latch;
      end else if (a == `REG_PC_OFS) begin
         read_word[14:0] = s.pc;
      end else if (a == `REG_STATUS_OFS) begin
         read_word[`STATUS_ZERO_BIT]      = s.zero;
         read_word[`STATUS_POWERDOWN_BIT] = s.powerdown_flag_n;
         read_word[`STATUS_TIMEOUT_BIT]   = s.timeout_flag_n;
      end
   endfunction : read_word

   // second cycle of a call or taken skip stalls the issue port
   assign instr_ready_o = (cur_ff.phase == st_exec);
   assign issue         = instr_valid_i && instr_ready_o;
   assign file_raddr_o  = instr_faddr_i;

   assign com_val = ~file_rdata_i;
   assign dec_val = file_rdata_i - `ONE_BYTE;

   assign s_axi_awready = !cur_ff.aw_held && !cur_ff.bvalid;
   assign s_axi_wready  = !cur_ff.w_held && !cur_ff.bvalid;
   assign s_axi_arready = !cur_ff.rvalid;
   assign wr_fire = cur_ff.aw_held && cur_ff.w_held && !cur_ff.bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always_comb begin
      nxt_cur           = cur_ff;
      nxt_cur.push      = 1'b0;
      nxt_cur.wdt_clear = 1'b0;
      nxt_cur.skip      = 1'b0;
      nxt_cur.file_we   = 1'b0;

      // software writes first so that an instruction in the same cycle wins
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_cur.aw_held = 1'b1;
         nxt_cur.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_cur.w_held = 1'b1;
         nxt_cur.wdata  = s_axi_wdata[7:0];
         nxt_cur.wstrb0 = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         nxt_cur.aw_held = 1'b0;
         nxt_cur.w_held  = 1'b0;
         nxt_cur.bvalid  = 1'b1;
         nxt_cur.bresp   = addr_mapped(cur_ff.awaddr) ? `RESP_OKAY
                                                      : `RESP_SLVERR;
         if (cur_ff.wstrb0 && cur_ff.awaddr == `REG_WORKING_OFS) begin
            nxt_cur.working = cur_ff.wdata;
         end
         if (cur_ff.wstrb0 && cur_ff.awaddr == `REG_PC_HIGH_OFS) begin
            nxt_cur.pc_high_latch = cur_ff.wdata;
         end
      end
      if (cur_ff.bvalid && s_axi_bready) begin
         nxt_cur.bvalid = 1'b0;
      end
      if (rd_fire) begin
         nxt_cur.rvalid = 1'b1;
         nxt_cur.rdata  = read_word(s_axi_araddr, cur_ff);
         nxt_cur.rresp  = addr_mapped(s_axi_araddr) ? `RESP_OKAY
                                                    : `RESP_SLVERR;
      end
      if (cur_ff.rvalid && s_axi_rready) begin
         nxt_cur.rvalid = 1'b0;
      end

      unique case (cur_ff.phase)
         st_exec: begin
            if (issue) begin
               nxt_cur.pc = cur_ff.pc + `ONE_PC;
               nxt_cur.file_waddr = instr_faddr_i;
               unique case (instr_op_i)
                  no_operation: begin
                  end
                  watchdog_clear_instr: begin
                     nxt_cur.wdt_clear        = 1'b1;
                     nxt_cur.timeout_flag_n   = 1'b1;
                     nxt_cur.powerdown_flag_n = 1'b1;
                  end
                  call_via_working_reg_instr: begin
                     nxt_cur.push      = 1'b1;
                     nxt_cur.push_addr = cur_ff.pc + `ONE_PC;
                     nxt_cur.pc[7:0]   = cur_ff.working;
                     nxt_cur.pc[14:8]  = cur_ff.pc_high_latch[6:0];
                     nxt_cur.phase     = st_second;
                  end
                  complement_reg_instr: begin
                     nxt_cur.zero = (com_val == `CLEAR_BYTE);
                     if (instr_dest_i) begin
                        nxt_cur.file_we    = 1'b1;
                        nxt_cur.file_wdata = com_val;
                     end else begin
                        nxt_cur.working = com_val;
                     end
                  end
                  clear_reg_instr: begin
                     nxt_cur.file_we    = 1'b1;
                     nxt_cur.file_wdata = `CLEAR_BYTE;
                     nxt_cur.zero       = 1'b1;
                  end
                  clear_working_reg_instr: begin
                     nxt_cur.working = `CLEAR_BYTE;
                     nxt_cur.zero    = 1'b1;
                  end
                  decrement_reg_instr: begin
                     nxt_cur.zero = (dec_val == `CLEAR_BYTE);
                     if (instr_dest_i) begin
                        nxt_cur.file_we    = 1'b1;
                        nxt_cur.file_wdata = dec_val;
                     end else begin
                        nxt_cur.working = dec_val;
                     end
                  end
                  decrement_skip_zero_instr: begin
                     // zero flag deliberately untouched here
                     if (instr_dest_i) begin
                        nxt_cur.file_we    = 1'b1;
                        nxt_cur.file_wdata = dec_val;
                     end else begin
                        nxt_cur.working = dec_val;
                     end
                     if (dec_val == `CLEAR_BYTE) begin
                        nxt_cur.skip  = 1'b1;
                        nxt_cur.phase = st_second;
                     end
                  end
               endcase
            end
         end
         st_second: begin
            // slot of the discarded fetch: nothing issues, pc advances only after a taken skip
            nxt_cur.phase = st_exec;
            if (cur_ff.skip) begin
               nxt_cur.pc = cur_ff.pc + `ONE_PC;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cur_ff                  <= '0;
         cur_ff.phase            <= st_exec;
         cur_ff.working          <= `WORKING_RST;
         cur_ff.pc_high_latch    <= `PC_HIGH_RST;
         cur_ff.pc               <= `PC_RST;
         cur_ff.zero             <= `ZERO_RST;
         cur_ff.timeout_flag_n   <= `FLAG_N_RST;
         cur_ff.powerdown_flag_n <= `FLAG_N_RST;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign file_we_o         = cur_ff.file_we;
   assign file_waddr_o      = cur_ff.file_waddr;
   assign file_wdata_o      = cur_ff.file_wdata;
   assign stack_push_o      = cur_ff.push;
   assign stack_push_addr_o = cur_ff.push_addr;
   assign wdt_clear_o       = cur_ff.wdt_clear;
   assign prescaler_clear_o = cur_ff.wdt_clear;
   assign skip_next_o       = cur_ff.skip;
   assign pc_o              = cur_ff.pc;
   assign s_axi_bvalid      = cur_ff.bvalid;
   assign s_axi_bresp       = cur_ff.bresp;
   assign s_axi_rvalid      = cur_ff.rvalid;
   assign s_axi_rdata       = cur_ff.rdata;
   assign s_axi_rresp       = cur_ff.rresp;

endmodule : instruction_exec_subset

// [testbench/instr_exec_assertions.sv]
module exec_checker (
   // clock, reset and issue
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        instr_valid_i,
   input wire logic        instr_ready_o,
   input wire instr_exec_pkg::op_type instr_op_i,
   input wire logic        instr_dest_i,
   input wire logic [7:0]  file_rdata_i,
   // results
   input wire logic        file_we_o,
   input wire logic [7:0]  file_wdata_o,
   input wire logic        stack_push_o,
   input wire logic [14:0] stack_push_addr_o,
   input wire logic        wdt_clear_o,
   input wire logic        prescaler_clear_o,
   input wire logic        skip_next_o,
   input wire logic [14:0] pc_o
);
   import instr_exec_pkg::*;
   wire take = instr_valid_i && instr_ready_o;
   wire wdt_t = take && instr_op_i == watchdog_clear_instr;
   wire call_t = take && instr_op_i == call_via_working_reg_instr;
   wire cpl_t = take && instr_op_i == complement_reg_instr;
   wire clr_t = take && instr_op_i == clear_reg_instr;
   wire dec_t = take && instr_op_i == decrement_reg_instr;
   wire dsz_t = take && instr_op_i == decrement_skip_zero_instr;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   property p_wdt; wdt_t |=> wdt_clear_o && prescaler_clear_o; endproperty
   a_wdt: assert property (p_wdt) else $error("wdt clear");
   property p_push;
      call_t |=> stack_push_o && stack_push_addr_o == $past(pc_o) + 15'h0001;
   endproperty
   a_push: assert property (p_push) else $error("push");
   property p_call; call_t |=> !instr_ready_o ##1 instr_ready_o; endproperty
   a_call: assert property (p_call) else $error("call cycles");
   property p_cpl;
      cpl_t && instr_dest_i |=>
         file_we_o && file_wdata_o == ~$past(file_rdata_i);
   endproperty
   a_cpl: assert property (p_cpl) else $error("complement");
   property p_clr; clr_t |=> file_we_o && file_wdata_o == 8'h00; endproperty
   a_clr: assert property (p_clr) else $error("clear reg");
   property p_dec;
      dec_t && instr_dest_i |=> file_wdata_o == $past(file_rdata_i) - 8'h01;
   endproperty
   a_dec: assert property (p_dec) else $error("decrement");
   property p_skip;
      dsz_t |=> skip_next_o == ($past(file_rdata_i) == 8'h01);
   endproperty
   a_skip: assert property (p_skip) else $error("skip");
   property p_dest;
      (cpl_t || dec_t || dsz_t) && !instr_dest_i |=> !file_we_o;
   endproperty
   a_dest: assert property (p_dest) else $error("dest");
   c_call: cover property (call_t);
   c_skip: cover property (skip_next_o);
   c_wdt: cover property (wdt_clear_o);
endmodule : exec_checker

bind instruction_exec_subset exec_checker chk (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
   .instr_ready_o(instr_ready_o), .instr_op_i(instr_op_i),
   .instr_dest_i(instr_dest_i), .file_rdata_i(file_rdata_i),
   .file_we_o(file_we_o), .file_wdata_o(file_wdata_o),
   .stack_push_o(stack_push_o), .stack_push_addr_o(stack_push_addr_o),
   .wdt_clear_o(wdt_clear_o), .prescaler_clear_o(prescaler_clear_o),
   .skip_next_o(skip_next_o), .pc_o(pc_o));

// [testbench/tb.sv]
`include "instr_exec_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import instr_exec_pkg::*;
   typedef struct packed {
      op_type op; logic [6:0] fa; logic d; logic [7:0] rd;
      logic we; logic [7:0] wd; logic sk;
   } row_type;
   row_type rows [7] = '{
      '{complement_reg_instr, 7'h03, 1'h1, 8'h5A, 1'h1, 8'hA5, 1'h0},
      '{decrement_reg_instr, 7'h00, 1'h1, 8'h00, 1'h1, 8'hFF, 1'h0},
      '{decrement_skip_zero_instr, 7'h22, 1'h1, 8'h02, 1'h1, 8'h01, 1'h0},
      '{decrement_skip_zero_instr, 7'h7F, 1'h1, 8'h01, 1'h1, 8'h00, 1'h1},
      '{watchdog_clear_instr, 7'h00, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0},
      '{clear_working_reg_instr, 7'h00, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0},
      '{clear_reg_instr, 7'h7F, 1'h0, 8'h55, 1'h1, 8'h00, 1'h0}};
   logic clk = 0, rst = 1, vld = 0, dst = 0, awv = 0, wv = 0, br = 0;
   logic arv = 0, rr = 0, rdy, we, push, wdt, psc, skip, awrdy, wrdy;
   logic bv, arrdy, rv;
   logic [6:0] fa = 0, wa, ra;
   logic [7:0] rd = 0, wd;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wdat = 0, rdat;
   logic [14:0] paddr, pc;
   logic [1:0] bresp, rresp;
   op_type op = no_operation;
   int error_cnt = 0, checks = 0;
   instruction_exec_subset dut (
      .ref_clk_i(clk), .rst_i(rst), .instr_valid_i(vld), .instr_ready_o(rdy),
      .instr_op_i(op), .instr_faddr_i(fa), .instr_dest_i(dst),
      .file_raddr_o(ra), .file_rdata_i(rd), .file_we_o(we), .file_waddr_o(wa),
      .file_wdata_o(wd), .stack_push_o(push), .stack_push_addr_o(paddr),
      .wdt_clear_o(wdt), .prescaler_clear_o(psc), .skip_next_o(skip),
      .pc_o(pc), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
      .s_axi_wdata(wdat), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
      .s_axi_arready(arrdy), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp));
   always #4 clk = ~clk;
   task automatic wrap_up();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   task automatic issue(input op_type o, input logic [6:0] f,
                        input logic d, input logic [7:0] r);
      int n;
      @(posedge clk);
      op <= o;
      {vld, fa, dst, rd} <= {1'h1, f, d, r};
      @(negedge clk);
      for (n = 0; n < 20 && !rdy; n++) @(negedge clk);
      if (n == 20) error_cnt++;
      if (n == 20) wrap_up();
      @(posedge clk);
      vld <= 1'h0;
      @(negedge clk);
   endtask : issue
   // valid held until the edge that samples ready, answer taken there
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [33:0] q);
      logic [3:0] t;
      @(posedge clk);
      {awv, wv, br, arv, rr} <= {w, w, w, !w, !w};
      {awa, ara, wdat} <= {a, a, d};
      for (int n = 0; n < 20; n++) begin
         @(negedge clk);
         t = {awrdy, wrdy, arrdy, w ? bv : rv};
         q = w ? {bresp, 32'h0000_0000} : {rresp, rdat};
         @(posedge clk);
         if (t[3]) awv <= 1'h0;
         if (t[2]) wv <= 1'h0;
         if (t[1]) arv <= 1'h0;
         if (t[0]) {br, rr} <= 2'h0;
         if (t[0]) return;
      end
      error_cnt++;
      wrap_up();
   endtask : bus
   task automatic rd_chk(input logic [11:0] a, input logic [33:0] e);
      logic [33:0] q;
      bus(1'h0, a, 32'h0000_0000, q);
      `CHK(q, e)
   endtask : rd_chk
   initial begin
      logic [33:0] q;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      rd_chk(12'h00C, {`RESP_OKAY, 32'h0000_0006});
      rd_chk(12'h008, {`RESP_OKAY, 32'h0000_0000});
      foreach (rows[i]) begin
         issue(rows[i].op, rows[i].fa, rows[i].d, rows[i].rd);
         `CHK({we, skip}, {rows[i].we, rows[i].sk})
         `CHK(rdy, !rows[i].sk)
         `CHK(ra, rows[i].fa)
         if (rows[i].we) `CHK({wa, wd}, {rows[i].fa, rows[i].wd})
         `CHK({wdt, psc}, {2{rows[i].op == watchdog_clear_instr}})
      end
      rd_chk(12'h00C, {`RESP_OKAY, 32'h0000_0007});
      issue(decrement_reg_instr, 7'h11, 1'h0, 8'h10);
      rd_chk(12'h000, {`RESP_OKAY, 32'h0000_000F});
      issue(clear_working_reg_instr, 7'h00, 1'h0, 8'h00);
      rd_chk(12'h00C, {`RESP_OKAY, 32'h0000_0007});
      issue(complement_reg_instr, 7'h05, 1'h0, 8'h0F);
      rd_chk(12'h000, {`RESP_OKAY, 32'h0000_00F0});
      issue(decrement_skip_zero_instr, 7'h05, 1'h0, 8'h01);
      rd_chk(12'h00C, {`RESP_OKAY, 32'h0000_0006});
      // bit 7 of the high latch must not reach the pc
      bus(1'h1, 12'h000, 32'h0000_003C, q);
      bus(1'h1, 12'h004, 32'h0000_00A5, q);
      // eleven issued ops plus two taken skips so far
      rd_chk(12'h008, {`RESP_OKAY, 32'h0000_000D});
      issue(call_via_working_reg_instr, 7'h00, 1'h0, 8'h00);
      `CHK({push, paddr}, {1'h1, 15'h000E})
      `CHK(pc, {7'h25, 8'h3C})
      `CHK(rdy, 1'h0)
      rd_chk(12'h100, {`RESP_SLVERR, 32'h0000_0000});
      bus(1'h1, 12'h008, 32'h0000_0000, q);
      `CHK(q[33:32], `RESP_OKAY)
      rd_chk(12'h008, {`RESP_OKAY, 17'h0_0000, 7'h25, 8'h3C});
      // reset in mid-run must bring back the power-up state
      @(posedge clk);
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rd_chk(12'h008, {`RESP_OKAY, 32'h0000_0000});
      rd_chk(12'h000, {`RESP_OKAY, 32'h0000_0000});
      rd_chk(12'h00C, {`RESP_OKAY, 32'h0000_0006});
      issue(clear_working_reg_instr, 7'h00, 1'h0, 8'h00);
      `CHK({we, skip, rdy}, 3'h1)
      rd_chk(12'h00C, {`RESP_OKAY, 32'h0000_0007});
      wrap_up();
   end
endmodule : tb
